// ==== logic/fpc_pkg.sv ====
// Package for the floating-point operand classifier and fault checker
package fpc_pkg;

   // ==========================================================
   // Data formats and field widths
   // ==========================================================
   typedef enum logic [1:0] {
      FPC_FMT_LSGL = 2'h0,   // Legacy single
      FPC_FMT_LDBL = 2'h1,   // Legacy double
      FPC_FMT_ISGL = 2'h2,   // IEEE single
      FPC_FMT_IDBL = 2'h3    // IEEE double
   } fpc_fmt_t;

   localparam int FPC_WORD_W   = 64;
   localparam int FPC_EXP_SGL  = 8;
   localparam int FPC_EXP_DBL  = 11;
   localparam int FPC_FRAC_SGL = 23;
   localparam int FPC_FRAC_DBL = 52;
   localparam int FPC_FRAC_EXT = 55;
   // Register image: sign 63, exponent 62 down, fraction below
   localparam int FPC_SIGN_POS = 63;
   localparam int FPC_EXP_TOP  = 62;
   // Single data stored with 52-bit fraction; low 29 bits unused
   localparam int FPC_FRAC_PAD = FPC_FRAC_DBL - FPC_FRAC_SGL;
   localparam logic [FPC_WORD_W-1:0] FPC_TRUE_ZERO = 64'h0000_0000_0000_0000;

   // ==========================================================
   // Rounding modes and instruction groups
   // ==========================================================
   typedef enum logic [1:0] {
      FPC_RND_CHOP = 2'h0,
      FPC_RND_MINF = 2'h1,
      FPC_RND_NORM = 2'h2,
      FPC_RND_DYN  = 2'h3
   } fpc_rnd_t;

   // Dynamic rounding field value that selects plus infinity
   localparam logic [1:0] FPC_DYN_PINF = 2'h3;
   localparam logic [1:0] FPC_DYN_MINF = 2'h1;
   localparam logic [1:0] FPC_DYN_NORM = 2'h2;
   localparam logic [1:0] FPC_DYN_CHOP = 2'h0;

   typedef enum logic [2:0] {
      FPC_OP_NONE   = 3'h0,
      FPC_OP_ARITH  = 3'h1,   // Operate, format specific
      FPC_OP_COMMON = 3'h2,   // Common to both subsets
      FPC_OP_CVT    = 3'h3,   // Conversion
      FPC_OP_LOAD   = 3'h4,
      FPC_OP_STORE  = 3'h5,
      FPC_OP_EXTARI = 3'h6    // Arithmetic on extended legacy format
   } fpc_op_t;

   typedef enum logic [1:0] {
      FPC_CVT_F2Q = 2'h0,
      FPC_CVT_Q2F = 2'h1,
      FPC_CVT_D2S = 2'h2,
      FPC_CVT_Q2L = 2'h3
   } fpc_cvt_t;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic       valid;
      fpc_op_t    op;
      fpc_fmt_t   fmt;
      fpc_rnd_t   rnd;
      logic [1:0] trap_mode;
      fpc_cvt_t   cvt;
   } fpc_instr_t;

   typedef struct packed {
      logic finite;
      logic zero;
      logic nan;
      logic inf;
      logic denorm;
      logic resv;
      logic dirty;
   } fpc_class_t;

   typedef struct packed {
      logic acv;
      logic tnv;
      logic for_f;
      logic fow_f;
      logic align;
   } fpc_mm_t;

   typedef struct packed {
      logic fp_disabled;
      logic illegal;
      logic mm_fault;
   } fpc_fault_t;

   // Fault check states
   typedef enum logic [1:0] {
      FPC_ST_IDLE  = 2'b00,
      FPC_ST_CHECK = 2'b01,
      FPC_ST_FAULT = 2'b11
   } fpc_state_t;

endpackage

// ==== logic/fpc_classify.sv ====
// Operand classifier for one 64-bit floating register image
`timescale 1ns/1ps
module fpc_classify (
   // Operand
   input  wire logic [63:0]        opnd_i,
   input  wire fpc_pkg::fpc_fmt_t  fmt_i,
   // Class flags
   output fpc_pkg::fpc_class_t     cls_o,
   output logic                    snan_o
);

   logic                               sign;
   logic [fpc_pkg::FPC_EXP_DBL-1:0]    expo;
   logic [fpc_pkg::FPC_FRAC_DBL-1:0]   frac;
   logic                               exp_ones;
   logic                               exp_zero;
   logic                               frac_zero;
   logic                               ieee;

   // Field split by format
   always_comb begin
      sign = opnd_i[fpc_pkg::FPC_SIGN_POS];
      frac = opnd_i[fpc_pkg::FPC_FRAC_DBL-1:0];
      ieee = (fmt_i == fpc_pkg::FPC_FMT_ISGL) || (fmt_i == fpc_pkg::FPC_FMT_IDBL);
      if (fmt_i == fpc_pkg::FPC_FMT_LSGL || fmt_i == fpc_pkg::FPC_FMT_ISGL) begin
         // Single exponent is rebiased in register; use top and 8-bit field
         expo = {3'h0, opnd_i[fpc_pkg::FPC_EXP_TOP -: fpc_pkg::FPC_EXP_SGL]};
         exp_ones = &opnd_i[fpc_pkg::FPC_EXP_TOP -: fpc_pkg::FPC_EXP_SGL];
         exp_zero = ~|opnd_i[fpc_pkg::FPC_EXP_TOP -: fpc_pkg::FPC_EXP_SGL];
         frac_zero = ~|frac[fpc_pkg::FPC_FRAC_DBL-1 -: fpc_pkg::FPC_FRAC_SGL];
      end else begin
         expo = opnd_i[fpc_pkg::FPC_EXP_TOP -: fpc_pkg::FPC_EXP_DBL];
         exp_ones = &expo;
         exp_zero = ~|expo;
         frac_zero = ~|frac;
      end
   end

   // Class decode
   // exponent fraction classes
   always_comb begin
      cls_o = '0;
      snan_o = 1'b0;
      if (exp_zero && frac_zero) begin
         if (!ieee && sign) begin
            cls_o.resv = 1'b1;
         end else begin
            cls_o.zero = 1'b1;
            cls_o.finite = 1'b1;
         end
      end else if (exp_zero) begin
         if (ieee) begin
            cls_o.denorm = 1'b1;
         end else if (sign) begin
            cls_o.resv = 1'b1;
         end else begin
            cls_o.dirty = 1'b1;
         end
      end else if (exp_ones && ieee) begin
         if (frac_zero) begin
            cls_o.inf = 1'b1;
         end else begin
            cls_o.nan = 1'b1;
            snan_o = frac[fpc_pkg::FPC_FRAC_DBL-1];
         end
      end else begin
         cls_o.finite = 1'b1;
      end
   end

endmodule

// ==== logic/fpc_zero_fix.sv ====
// Result path that forces legacy zero results to true zero
`timescale 1ns/1ps
module fpc_zero_fix (
   // Raw result
   input  wire logic [63:0]        res_i,
   input  wire fpc_pkg::fpc_fmt_t  fmt_i,
   input  wire logic               is_operate_i,
   // Fixed result
   output logic [63:0]             res_o,
   output logic                    forced_o
);

   logic                             legacy;
   logic [fpc_pkg::FPC_EXP_DBL-1:0]  expo;

   // Zero value has a cleared exponent in legacy formats
   always_comb begin
      legacy = (fmt_i == fpc_pkg::FPC_FMT_LSGL) || (fmt_i == fpc_pkg::FPC_FMT_LDBL);
      if (fmt_i == fpc_pkg::FPC_FMT_LSGL) begin
         expo = {3'h0, res_i[fpc_pkg::FPC_EXP_TOP -: fpc_pkg::FPC_EXP_SGL]};
      end else begin
         expo = res_i[fpc_pkg::FPC_EXP_TOP -: fpc_pkg::FPC_EXP_DBL];
      end
      forced_o = is_operate_i && legacy && (expo == '0);
      res_o = forced_o ? fpc_pkg::FPC_TRUE_ZERO : res_i;
   end

endmodule

// ==== logic/fpc_check.sv ====
// Floating operand classifier and floating fault checker, top level
//
// Operation
// - Legacy-format zero results of operate instructions are written as true zero.
// - True zero is sixty-four cleared bits.
// - Implemented float instruction with enable bit clear raises disabled fault.
// - Unimplemented float instruction raises illegal trap regardless of enable bit.
// - Either subset present implies every common instruction is implemented.
// - Omitted plus/minus infinity rounding makes such requests illegal.
// - Loads and stores pass memory management faults.
// - Fields: 1-bit sign, 8 or 11 exponent, 23/52/55 fraction.
// - Classify by exponent all ones, zero, fraction and sign per family.
// - IEEE NaN with leading fraction one is signaling, else quiet.
// - Legacy reserved operands and dirty zeros are not finite.
// - IEEE infinity, NaN, denormal not finite; minus zero finite.
// - Finite values lie in minus MAX..minus MIN, zero, MIN..MAX.
// - No arithmetic on extended legacy format; conversions only.
// - Format and trap mode come from the instruction fields; IEEE dynamic rounding comes from the control field.
// - Conversions float/quad, double/single, quad/long are supported.
// - Plus infinity rounding only via dynamic mode with control field 11.
`timescale 1ns/1ps
module fpc_check #(
   parameter bit HAS_LEGACY = 1'b1,
   parameter bit HAS_IEEE   = 1'b1,
   parameter bit HAS_INFRND = 1'b1
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   // Issue from decode
   input  wire fpc_pkg::fpc_instr_t  instr_i,
   input  wire logic                 fp_enable_bit_i,
   input  wire logic [1:0]           fp_control_register_dyn_i,
   // Operands from register file
   input  wire logic [63:0]          opnd_a_i,
   input  wire logic [63:0]          opnd_b_i,
   // Memory management status of a load or store
   input  wire fpc_pkg::fpc_mm_t     mm_i,
   // Raw result from execution
   input  wire logic [63:0]          result_i,
   // Classes, same cycle as operands
   output fpc_pkg::fpc_class_t       cls_a_o,
   output fpc_pkg::fpc_class_t       cls_b_o,
   output logic                      snan_a_o,
   output logic                      snan_b_o,
   // Registered result and faults
   output logic [63:0]               wr_data_o,
   output logic                      wr_en_o,
   output fpc_pkg::fpc_fault_t       fault_o,
   output fpc_pkg::fpc_mm_t          mm_fault_o,
   output fpc_pkg::fpc_rnd_t         eff_rnd_o,
   output logic [1:0]                trap_mode_o
);

   // ==========================================================
   // Classification
   // ==========================================================
   logic              snan_a;
   logic              snan_b;
   logic [63:0]       fixed_res;
   logic              forced;
   logic              is_oper;
   logic              int_res;

   // Operand decode, combinational
   // field widths
   fpc_classify u_cls_a (
      .opnd_i (opnd_a_i),
      .fmt_i  (instr_i.fmt),
      .cls_o  (cls_a_o),
      .snan_o (snan_a)
   );

   fpc_classify u_cls_b (
      .opnd_i (opnd_b_i),
      .fmt_i  (instr_i.fmt),
      .cls_o  (cls_b_o),
      .snan_o (snan_b)
   );

   assign snan_a_o = snan_a;
   assign snan_b_o = snan_b;

   // ==========================================================
   // Legality decode
   // ==========================================================
   function automatic logic fmt_ok(input fpc_pkg::fpc_fmt_t f);
      fmt_ok = ((f == fpc_pkg::FPC_FMT_LSGL || f == fpc_pkg::FPC_FMT_LDBL) && HAS_LEGACY)
            || ((f == fpc_pkg::FPC_FMT_ISGL || f == fpc_pkg::FPC_FMT_IDBL) && HAS_IEEE);
   endfunction

   function automatic logic is_ieee(input fpc_pkg::fpc_fmt_t f);
      is_ieee = (f == fpc_pkg::FPC_FMT_ISGL) || (f == fpc_pkg::FPC_FMT_IDBL);
   endfunction

   logic              implemented;
   logic              inf_rnd_req;
   fpc_pkg::fpc_rnd_t eff_rnd;

   // Implemented check and effective rounding
   always_comb begin
      eff_rnd = instr_i.rnd;
      if (instr_i.rnd == fpc_pkg::FPC_RND_DYN && is_ieee(instr_i.fmt)) begin
         unique case (fp_control_register_dyn_i)
            fpc_pkg::FPC_DYN_PINF: eff_rnd = fpc_pkg::FPC_RND_DYN;
            fpc_pkg::FPC_DYN_MINF: eff_rnd = fpc_pkg::FPC_RND_MINF;
            fpc_pkg::FPC_DYN_NORM: eff_rnd = fpc_pkg::FPC_RND_NORM;
            fpc_pkg::FPC_DYN_CHOP: eff_rnd = fpc_pkg::FPC_RND_CHOP;
         endcase
      end
      inf_rnd_req = is_ieee(instr_i.fmt) && (eff_rnd == fpc_pkg::FPC_RND_MINF
                    || eff_rnd == fpc_pkg::FPC_RND_DYN);
      // common ops exist if any subset does
      unique case (instr_i.op)
         fpc_pkg::FPC_OP_COMMON,
         fpc_pkg::FPC_OP_LOAD,
         fpc_pkg::FPC_OP_STORE:  implemented = HAS_LEGACY || HAS_IEEE;
         // all conversion kinds; integer narrowing is common
         fpc_pkg::FPC_OP_CVT:    implemented = (instr_i.cvt == fpc_pkg::FPC_CVT_Q2L) ?
                                               (HAS_LEGACY || HAS_IEEE) : fmt_ok(instr_i.fmt);
         fpc_pkg::FPC_OP_ARITH:  implemented = fmt_ok(instr_i.fmt);
         fpc_pkg::FPC_OP_EXTARI: implemented = 1'b0;
         default:                implemented = 1'b0;
      endcase
      if (!HAS_INFRND && inf_rnd_req && instr_i.op != fpc_pkg::FPC_OP_LOAD
          && instr_i.op != fpc_pkg::FPC_OP_STORE) begin
         implemented = 1'b0;
      end
   end

   // ==========================================================
   // Result path
   // ==========================================================
   // Integer-result conversions hold no floating zero to fix
   assign int_res = (instr_i.cvt == fpc_pkg::FPC_CVT_F2Q) ||
                    (instr_i.cvt == fpc_pkg::FPC_CVT_Q2L);
   assign is_oper = (instr_i.op == fpc_pkg::FPC_OP_ARITH) ||
                    (instr_i.op == fpc_pkg::FPC_OP_COMMON) ||
                    ((instr_i.op == fpc_pkg::FPC_OP_CVT) && !int_res);

   fpc_zero_fix u_zfix (
      .res_i        (result_i),
      .fmt_i        (instr_i.fmt),
      .is_operate_i (is_oper),
      .res_o        (fixed_res),
      .forced_o     (forced)
   );

   // ==========================================================
   // Issue sequencing and registered outputs
   // ==========================================================
   fpc_pkg::fpc_state_t  state_r, state_nxt;
   logic [63:0]          wr_data_r, wr_data_nxt;
   logic                 wr_en_r, wr_en_nxt;
   fpc_pkg::fpc_fault_t  fault_r, fault_nxt;
   fpc_pkg::fpc_mm_t     mmf_r, mmf_nxt;
   fpc_pkg::fpc_rnd_t    rnd_r, rnd_nxt;
   logic [1:0]           trap_r, trap_nxt;

   // Next-state and fault decode
   always_comb begin
      state_nxt   = fpc_pkg::FPC_ST_IDLE;
      wr_data_nxt = wr_data_r;
      wr_en_nxt   = 1'b0;
      fault_nxt   = '0;
      mmf_nxt     = '0;
      rnd_nxt     = rnd_r;
      trap_nxt    = trap_r;
      if (instr_i.valid && instr_i.op != fpc_pkg::FPC_OP_NONE) begin
         state_nxt = fpc_pkg::FPC_ST_CHECK;
         rnd_nxt  = eff_rnd;
         trap_nxt = instr_i.trap_mode;
         if (!implemented) begin
            fault_nxt.illegal = 1'b1;
            state_nxt = fpc_pkg::FPC_ST_FAULT;
         end else if (!fp_enable_bit_i) begin
            fault_nxt.fp_disabled = 1'b1;
            state_nxt = fpc_pkg::FPC_ST_FAULT;
         end else if ((instr_i.op == fpc_pkg::FPC_OP_LOAD ||
                       instr_i.op == fpc_pkg::FPC_OP_STORE) && (|mm_i)) begin
            fault_nxt.mm_fault = 1'b1;
            mmf_nxt = mm_i;
            state_nxt = fpc_pkg::FPC_ST_FAULT;
         end else if (instr_i.op != fpc_pkg::FPC_OP_STORE) begin
            wr_data_nxt = fixed_res;
            wr_en_nxt   = 1'b1;
         end
      end
   end

   // State registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r   <= fpc_pkg::FPC_ST_IDLE;
         wr_data_r <= fpc_pkg::FPC_TRUE_ZERO;
         wr_en_r   <= 1'b0;
         fault_r   <= '0;
         mmf_r     <= '0;
         rnd_r     <= fpc_pkg::FPC_RND_NORM;
         trap_r    <= 2'h0;
      end else begin
         state_r   <= state_nxt;
         wr_data_r <= wr_data_nxt;
         wr_en_r   <= wr_en_nxt;
         fault_r   <= fault_nxt;
         mmf_r     <= mmf_nxt;
         rnd_r     <= rnd_nxt;
         trap_r    <= trap_nxt;
      end
   end

   assign wr_data_o   = wr_data_r;
   assign wr_en_o     = wr_en_r;
   assign fault_o     = fault_r;
   assign mm_fault_o  = mmf_r;
   assign eff_rnd_o   = rnd_r;
   assign trap_mode_o = trap_r;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_ZERO_FORCED: assert property (
      instr_i.valid && implemented && fp_enable_bit_i && is_oper && forced
      |=> wr_en_o && wr_data_o == 64'h0)
      else $error("legacy zero result not written as true zero");

   AST_DISABLED: assert property (
      instr_i.valid && instr_i.op != fpc_pkg::FPC_OP_NONE && implemented && !fp_enable_bit_i
      |=> fault_o.fp_disabled && !wr_en_o)
      else $error("disabled fault missing");

   AST_ILLEGAL: assert property (
      instr_i.valid && instr_i.op == fpc_pkg::FPC_OP_EXTARI
      |=> fault_o.illegal && !fault_o.fp_disabled)
      else $error("illegal trap missing");

   AST_MM: assert property (
      instr_i.valid && instr_i.op == fpc_pkg::FPC_OP_LOAD && implemented
      && fp_enable_bit_i && |mm_i |=> fault_o.mm_fault && mm_fault_o == $past(mm_i))
      else $error("memory fault not passed");

   AST_ONEHOT: assert property (
      $onehot({cls_a_o.zero | cls_a_o.finite & ~cls_a_o.zero, cls_a_o.nan,
               cls_a_o.inf, cls_a_o.denorm, cls_a_o.resv, cls_a_o.dirty}))
      else $error("class flags not one-hot");

   AST_IEEE_NONFIN: assert property (
      is_ieee(instr_i.fmt) && (cls_a_o.nan || cls_a_o.inf || cls_a_o.denorm)
      |-> !cls_a_o.finite)
      else $error("IEEE special marked finite");

   AST_LEG_NONFIN: assert property (
      !is_ieee(instr_i.fmt) |-> !(cls_a_o.nan || cls_a_o.inf || cls_a_o.denorm)
      && ((cls_a_o.resv || cls_a_o.dirty) != cls_a_o.finite))
      else $error("legacy class wrong");

   AST_SNAN: assert property (
      snan_a_o |-> cls_a_o.nan && opnd_a_i[fpc_pkg::FPC_FRAC_DBL-1])
      else $error("signaling NaN misflagged");

   AST_PINF: assert property (
      instr_i.valid && instr_i.rnd == fpc_pkg::FPC_RND_DYN && is_ieee(instr_i.fmt)
      && fp_control_register_dyn_i == 2'h3 && instr_i.op == fpc_pkg::FPC_OP_ARITH
      |=> eff_rnd_o == fpc_pkg::FPC_RND_DYN)
      else $error("plus infinity rounding not selected");

   AST_FAULT_STATE: assert property (
      (state_r == fpc_pkg::FPC_ST_FAULT) == (|fault_o))
      else $error("fault state and fault flags disagree");

   COV_WRITE:   cover property (wr_en_o);
   COV_ILLEGAL: cover property (fault_o.illegal);
   COV_DISABLE: cover property (fault_o.fp_disabled);
   COV_NAN:     cover property (cls_a_o.nan);

endmodule

// ==== tb/fpc_pipe_model.sv ====
// Register file model on the far side of the floating checker
`timescale 1ns/1ps
module fpc_pipe_model (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   // Write port and faults from the checker
   input  wire logic                 wr_en_i,
   input  wire logic [63:0]          wr_data_i,
   input  wire fpc_pkg::fpc_fault_t  fault_i,
   // Observed state
   output logic [63:0]               last_o,
   output logic [7:0]                wr_cnt_o,
   output logic [7:0]                flt_cnt_o
);
   logic [63:0] last_r;
   logic [63:0] last_nxt;
   logic [7:0]  wr_cnt_r;
   logic [7:0]  wr_cnt_nxt;
   logic [7:0]  flt_cnt_r;
   logic [7:0]  flt_cnt_nxt;

   // Capture writes and count them; faults never update the image
   always_comb begin
      last_nxt    = last_r;
      wr_cnt_nxt  = wr_cnt_r;
      flt_cnt_nxt = flt_cnt_r;
      if (wr_en_i) begin
         last_nxt   = wr_data_i;
         wr_cnt_nxt = wr_cnt_r + 8'h01;
      end
      if (|fault_i) begin
         flt_cnt_nxt = flt_cnt_r + 8'h01;
      end
   end

   // Registers of the model
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_r    <= 64'h0;
         wr_cnt_r  <= 8'h0;
         flt_cnt_r <= 8'h0;
      end else begin
         last_r    <= last_nxt;
         wr_cnt_r  <= wr_cnt_nxt;
         flt_cnt_r <= flt_cnt_nxt;
      end
   end

   assign last_o    = last_r;
   assign wr_cnt_o  = wr_cnt_r;
   assign flt_cnt_o = flt_cnt_r;
endmodule

// ==== tb/tb_top.sv ====
// Self-checking testbench of the floating classifier and fault checker
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
   // ==========================================================
   // Signals
   // ==========================================================
   logic                 clk_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   fpc_pkg::fpc_instr_t  instr_i = '0;
   logic                 fp_enable_bit_i = 1'b1;
   logic [1:0]           fp_control_register_dyn_i = 2'h2;
   logic [63:0]          opnd_a_i = 64'h0;
   logic [63:0]          opnd_b_i = 64'h0;
   fpc_pkg::fpc_mm_t     mm_i = '0;
   logic [63:0]          result_i = 64'h0;
   fpc_pkg::fpc_class_t  cls_a_o;
   fpc_pkg::fpc_class_t  cls_b_o;
   logic                 snan_a_o;
   logic                 snan_b_o;
   logic [63:0]          wr_data_o;
   logic                 wr_en_o;
   fpc_pkg::fpc_fault_t  fault_o;
   fpc_pkg::fpc_mm_t     mm_fault_o;
   fpc_pkg::fpc_rnd_t    eff_rnd_o;
   logic [1:0]           trap_mode_o;
   fpc_pkg::fpc_fault_t  fault_nr;
   logic [63:0]          last;
   logic [7:0]           wr_cnt;
   logic [7:0]           flt_cnt;
   fpc_pkg::fpc_cvt_t    cvt_s = fpc_pkg::FPC_CVT_F2Q;
   int                   n_fail = 0;
   int                   n_compared = 0;

   // Classification table: operand, format, {class flags, signaling}
   logic [63:0] cv [13] = '{64'h7ff0_0000_0000_0001, 64'h7ff0_0000_0000_0001,
      64'h7ff8_0000_0000_0000, 64'h7ff0_0000_0000_0000, 64'h0000_0000_0000_0001,
      64'h0000_0000_0000_0001, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0000,
      64'h8000_0000_0000_0000, 64'h0000_0000_0000_0000, 64'h7f80_0000_0000_0000,
      64'h3ff0_0000_0000_0000, 64'h0000_0000_2000_0000};
   logic [1:0] cf [13] = '{2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h3,
      2'h0, 2'h2, 2'h0, 2'h2};
   logic [7:0] ce [13] = '{8'h80, 8'h20, 8'h21, 8'h10, 8'h08, 8'h02, 8'h04, 8'h04,
      8'hc0, 8'hc0, 8'h10, 8'h80, 8'h08};

   // ==========================================================
   // Design, far-side model, clock
   // ==========================================================
   fpc_check i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
      .fp_enable_bit_i(fp_enable_bit_i), .fp_control_register_dyn_i(fp_control_register_dyn_i),
      .opnd_a_i(opnd_a_i), .opnd_b_i(opnd_b_i), .mm_i(mm_i), .result_i(result_i),
      .cls_a_o(cls_a_o), .cls_b_o(cls_b_o), .snan_a_o(snan_a_o), .snan_b_o(snan_b_o),
      .wr_data_o(wr_data_o), .wr_en_o(wr_en_o), .fault_o(fault_o),
      .mm_fault_o(mm_fault_o), .eff_rnd_o(eff_rnd_o), .trap_mode_o(trap_mode_o));

   fpc_pipe_model i_pipe (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_o),
      .wr_data_i(wr_data_o), .fault_i(fault_o), .last_o(last), .wr_cnt_o(wr_cnt),
      .flt_cnt_o(flt_cnt));

   // Second copy without infinity rounding, faults only
   fpc_check #(.HAS_INFRND(1'b0)) i_dut_nr (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .instr_i(instr_i), .fp_enable_bit_i(fp_enable_bit_i),
      .fp_control_register_dyn_i(fp_control_register_dyn_i), .opnd_a_i(opnd_a_i),
      .opnd_b_i(opnd_b_i), .mm_i(mm_i), .result_i(result_i), .cls_a_o(), .cls_b_o(),
      .snan_a_o(), .snan_b_o(), .wr_data_o(), .wr_en_o(), .fault_o(fault_nr),
      .mm_fault_o(), .eff_rnd_o(), .trap_mode_o());

   // 100 ns clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // ==========================================================
   // Shared tasks
   // ==========================================================
   // Present one instruction, let it be taken, sample after the answer edge
   task automatic issue(input fpc_pkg::fpc_op_t op, input fpc_pkg::fpc_fmt_t fmt,
                        input fpc_pkg::fpc_rnd_t rnd, input logic en,
                        input logic [63:0] res, input fpc_pkg::fpc_mm_t mm);
      @(posedge clk_i);
      instr_i <= '{valid: 1'b1, op: op, fmt: fmt, rnd: rnd, trap_mode: 2'h2, cvt: cvt_s};
      fp_enable_bit_i <= en;
      result_i <= res;
      mm_i <= mm;
      @(posedge clk_i);
      instr_i <= '0;
      mm_i <= '0;
      #1;
   endtask

   // Compare write strobe, fault bits and, on a write, the data
   task automatic expect_out(input logic we, input logic [2:0] flt, input logic [63:0] dat);
      `CHK(wr_en_o, we)
      `CHK(fault_o, flt)
      if (we) `CHK(wr_data_o, dat)
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      expect_out(1'b0, 3'h0, 64'h0);
      `CHK(eff_rnd_o, fpc_pkg::FPC_RND_NORM)
   endtask

   // Every encoding row of the class table, both operand ports
   task automatic t_classify();
      for (int i = 0; i < 13; i++) begin
         @(posedge clk_i);
         opnd_a_i <= cv[i];
         opnd_b_i <= cv[i];
         instr_i.fmt <= fpc_pkg::fpc_fmt_t'(cf[i]);
         #1;
         `CHK({cls_a_o, snan_a_o}, ce[i])
         `CHK({cls_b_o, snan_b_o}, ce[i])
      end
   endtask

   // Legacy zero results become all-clear; IEEE minus zero is kept
   task automatic t_zero();
      issue(fpc_pkg::FPC_OP_ARITH, fpc_pkg::FPC_FMT_LSGL, fpc_pkg::FPC_RND_NORM, 1'b1,
            64'h8000_0000_2000_0000, '0);
      expect_out(1'b1, 3'h0, fpc_pkg::FPC_TRUE_ZERO);
      issue(fpc_pkg::FPC_OP_COMMON, fpc_pkg::FPC_FMT_LDBL, fpc_pkg::FPC_RND_CHOP, 1'b1,
            64'h0000_0000_0000_0001, '0);
      expect_out(1'b1, 3'h0, 64'h0);
      `CHK(last, 64'h0)
      issue(fpc_pkg::FPC_OP_ARITH, fpc_pkg::FPC_FMT_IDBL, fpc_pkg::FPC_RND_NORM, 1'b1,
            64'h8000_0000_0000_0000, '0);
      expect_out(1'b1, 3'h0, 64'h8000_0000_0000_0000);
   endtask

   // Disabled fault versus illegal trap, both enable values
   task automatic t_enable();
      issue(fpc_pkg::FPC_OP_ARITH, fpc_pkg::FPC_FMT_IDBL, fpc_pkg::FPC_RND_NORM, 1'b0,
            64'h3ff0_0000_0000_0000, '0);
      expect_out(1'b0, 3'h4, 64'h0);
      issue(fpc_pkg::FPC_OP_EXTARI, fpc_pkg::FPC_FMT_LDBL, fpc_pkg::FPC_RND_NORM, 1'b0,
            64'h3ff0_0000_0000_0000, '0);
      expect_out(1'b0, 3'h2, 64'h0);
      issue(fpc_pkg::FPC_OP_EXTARI, fpc_pkg::FPC_FMT_LDBL, fpc_pkg::FPC_RND_NORM, 1'b1,
            64'h3ff0_0000_0000_0000, '0);
      expect_out(1'b0, 3'h2, 64'h0);
   endtask

   // Each memory status bit on a load and a store; clean store never writes
   task automatic t_mm();
      logic [7:0] n0;
      for (int i = 0; i < 5; i++) begin
         issue(fpc_pkg::FPC_OP_LOAD, fpc_pkg::FPC_FMT_IDBL, fpc_pkg::FPC_RND_NORM, 1'b1,
               64'h0, fpc_pkg::fpc_mm_t'(5'h01 << i));
         expect_out(1'b0, 3'h1, 64'h0);
         `CHK(mm_fault_o, 5'h01 << i)
         issue(fpc_pkg::FPC_OP_STORE, fpc_pkg::FPC_FMT_LSGL, fpc_pkg::FPC_RND_NORM, 1'b1,
               64'h0, fpc_pkg::fpc_mm_t'(5'h10 >> i));
         expect_out(1'b0, 3'h1, 64'h0);
      end
      n0 = wr_cnt;
      issue(fpc_pkg::FPC_OP_STORE, fpc_pkg::FPC_FMT_IDBL, fpc_pkg::FPC_RND_NORM, 1'b1,
            64'h0, '0);
      expect_out(1'b0, 3'h0, 64'h0);
      @(posedge clk_i);
      #1;
      `CHK(wr_cnt, n0)
      `CHK(flt_cnt, 8'h0d)
   endtask

   // Rounding from instruction or dynamic field, and all conversions
   task automatic t_round_cvt();
      @(posedge clk_i);
      fp_control_register_dyn_i <= 2'h3;
      issue(fpc_pkg::FPC_OP_ARITH, fpc_pkg::FPC_FMT_IDBL, fpc_pkg::FPC_RND_DYN, 1'b1,
            64'h4000_0000_0000_0000, '0);
      expect_out(1'b1, 3'h0, 64'h4000_0000_0000_0000);
      `CHK(eff_rnd_o, fpc_pkg::FPC_RND_DYN)
      `CHK(trap_mode_o, 2'h2)
      `CHK(fault_nr, 3'h2)
      @(posedge clk_i);
      fp_control_register_dyn_i <= 2'h1;
      issue(fpc_pkg::FPC_OP_ARITH, fpc_pkg::FPC_FMT_ISGL, fpc_pkg::FPC_RND_DYN, 1'b1,
            64'h4000_0000_0000_0000, '0);
      `CHK(eff_rnd_o, fpc_pkg::FPC_RND_MINF)
      `CHK(fault_nr, 3'h2)
      issue(fpc_pkg::FPC_OP_ARITH, fpc_pkg::FPC_FMT_IDBL, fpc_pkg::FPC_RND_CHOP, 1'b1,
            64'h4000_0000_0000_0000, '0);
      `CHK(eff_rnd_o, fpc_pkg::FPC_RND_CHOP)
      `CHK(fault_nr, 3'h0)
      for (int c = 0; c < 4; c++) begin
         cvt_s = fpc_pkg::fpc_cvt_t'(c);
         issue(fpc_pkg::FPC_OP_CVT, fpc_pkg::FPC_FMT_LDBL, fpc_pkg::FPC_RND_NORM, 1'b1,
               64'h0000_0000_0000_0005, '0);
         // Integer results pass untouched, floating zero is forced
         expect_out(1'b1, 3'h0, (c % 3 == 0) ? 64'h5 : 64'h0);
      end
   endtask

   // ==========================================================
   // Main sequence and watchdog
   // ==========================================================
   initial begin
      repeat (3) @(posedge clk_i);
      t_reset();
      rst_n_i <= 1'b1;
      t_classify();
      t_zero();
      t_enable();
      t_mm();
      t_round_cvt();
      repeat (2) @(posedge clk_i);
      stop_test();
   end

   // Cut a hang short
   initial begin
      #2_000_000;
      n_fail++;
      stop_test();
   end
endmodule
